// File: verilog/qia_pkg.sv
// Shared constants for the quad UART interrupt arbiter
package qia_pkg;
	// Register indices on the plain register port
	localparam logic [4:0] ADDR_CTRL      = 5'h00; // Threshold [7:2], vector control [1:0]
	localparam logic [4:0] ADDR_VEC_BASE  = 5'h01;
	localparam logic [4:0] ADDR_MASK_LO   = 5'h02; // Sources 7:0
	localparam logic [4:0] ADDR_MASK_MID  = 5'h03; // Sources 15:8
	localparam logic [4:0] ADDR_MASK_HI   = 5'h04; // Sources 17:16
	localparam logic [4:0] ADDR_CT_PROG   = 5'h05; // Counter/timer ab [1:0], cd [3:2]
	localparam logic [4:0] ADDR_COMMAND   = 5'h06; // Write bit 0: refresh capture
	localparam logic [4:0] ADDR_CAPTURE   = 5'h07; // Current interrupt capture, read only
	localparam logic [4:0] ADDR_GLB_COUNT = 5'h08;
	localparam logic [4:0] ADDR_GLB_CHAN  = 5'h09;
	localparam logic [4:0] ADDR_GLB_DATA  = 5'h0A; // Read: receive, write: transmit
	localparam logic [4:0] ADDR_MODE0     = 5'h0C; // Plus channel
	localparam logic [4:0] ADDR_MODE1     = 5'h10; // Plus channel
	localparam logic [4:0] ADDR_LOC_DATA  = 5'h14; // Plus channel
	localparam logic [4:0] ADDR_SRC_PROG  = 5'h18; // Plus channel: break [2:0], change [5:3]

	// Field positions
	localparam int THRESH_LSB   = 2;
	localparam int RX_SEL0_BIT  = 6; // In mode register zero
	localparam int RX_SEL1_BIT  = 6; // In mode register one
	localparam int TX_SEL_HI    = 5;
	localparam int TX_SEL_LO    = 4;
	localparam int CMD_REFRESH  = 0;

	// Hard-wired type codes, bid bits 4:2
	localparam logic [2:0] TYPE_RX_OK  = 3'h3;
	localparam logic [2:0] TYPE_RX_ERR = 3'h7;
	localparam logic [2:0] TYPE_TX     = 3'h2;
	localparam logic [2:0] TYPE_BREAK  = 3'h4;
	localparam logic [2:0] TYPE_CHANGE = 3'h1;
	localparam logic [2:0] TYPE_TIMER  = 3'h5;
	localparam logic [1:0] CHAN_CT_AB  = 2'h1;
	localparam logic [1:0] CHAN_CT_CD  = 2'h3;

	// Vector control codes
	localparam logic [1:0] IVC_BASE = 2'h0;
	localparam logic [1:0] IVC_CHAN = 2'h1;
	localparam logic [1:0] IVC_TYPE = 2'h2;
	localparam logic [1:0] IVC_NONE = 2'h3;

	// Reset values and counts
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [7:0] NO_WINNER   = 8'hFF;
	localparam int         NUM_CHAN    = 4;
	localparam int         NUM_SRC     = 18;
	localparam logic [3:0] FIFO_DEPTH  = 4'h8;

	// Acknowledge sequencer
	typedef enum logic [1:0] {
		QIA_ACK_IDLE    = 2'b00,
		QIA_ACK_CAPTURE = 2'b01,
		QIA_ACK_DRIVE   = 2'b10,
		QIA_ACK_WAIT    = 2'b11
	} qia_ack_state_t;
endpackage

// File: verilog/qia_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module qia_pin_sync #(
	parameter int         WIDTH = 1,
	parameter logic [0:0] INIT  = 1'b1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	// Stage one feeds stage two only; metastability settles there
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= {WIDTH{INIT}};
			s2_reg <= {WIDTH{INIT}};
			s3_reg <= {WIDTH{INIT}};
		end else if (ce) begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level <= {WIDTH{INIT}};
		end else if (ce) begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					level[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule

// File: verilog/qia_arbiter.sv
// Interrupt arbitration, capture and acknowledge logic for a four-channel UART
//
// Functional notes
// - FIFO accesses, global or local, pulse a pop/push so the byte count drops.
// - Break, change and timer bids follow their source condition levels.
// - Request output follows the latched winner against the threshold every cycle.
// - End of evaluate latches the winning channel, count and type.
// - Capture register loads only on acknowledge or refresh command.
// - Data interrupts put the sampled byte count in capture bits 7:5.
// - Other types put their programmable high field in capture bits 7:5.
// - Global count and channel reads come from capture fields.
// - Global holding accesses go to the channel held in capture.
// - Global count gives bytes for data types, programmable field otherwise.
// - No bid above threshold: request inactive, presented value all ones.
// - Enabled sources above threshold compete each cycle; highest wins.
// - Receiver bids at 1, 3, 6 or exactly 8 bytes by select.
// - Transmitter bids at 8, 4, 6 or 1 free slots by select.
// - Transmit FIFO empty after reset; enabled transmitter bids at once.
// - Transmitter bid MSB is zero, so threshold 100000 blocks it.
// - Vector control picks base, base plus channel, or base, type, channel.
// - Vector control 11 drives no vector but still acknowledges.
// - Acknowledge drives the vector on the data lines and pulses acknowledge in the same cycle.
// - Receiver select other than 00, or transmitter select other than 11, withholds a bid until that level.
// - Bids carry channel in bits 1:0, type in bits 4:2; timers use 01, 11.
// - Empty receiver and full transmitter never bid; no bids reads FFh.
// - Acknowledge in evaluate keeps prior result, else next evaluate is skipped.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module qia_arbiter (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic [4:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic [15:0] rx_count,
	input  wire logic [15:0] tx_free,
	input  wire logic [3:0]  rx_error,
	input  wire logic [3:0]  tx_enabled,
	input  wire logic [3:0]  break_det,
	input  wire logic [3:0]  change_det,
	input  wire logic [1:0]  timer_ready,
	input  wire logic [31:0] rx_data,
	output logic      [3:0]  rx_pop,
	output logic      [3:0]  tx_push,
	output logic      [7:0]  tx_data,
	input  wire logic        interrupt_ack_n,
	output logic             interrupt_request_n_out,
	output logic             interrupt_request_n_oe_n,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n,
	output logic             transfer_ack_n
);
	logic [7:0]            interrupt_control_reg;
	logic [7:0]            vector_base_value;
	logic [17:0]           interrupt_mask_reg;
	logic [3:0]            timer_prog_reg;
	logic [7:0]            mode_reg_zero [qia_pkg::NUM_CHAN];
	logic [7:0]            mode_reg_one  [qia_pkg::NUM_CHAN];
	logic [5:0]            src_prog_reg  [qia_pkg::NUM_CHAN];
	logic [7:0]            bus_latch_reg;
	logic                  win_valid_reg;
	logic                  arbitration_evaluate_reg;
	logic                  arbitration_evaluate_inhibit_reg;
	logic [7:0]            current_interrupt_capture;
	qia_pkg::qia_ack_state_t ack_state_reg;
	logic [7:0]            bid     [qia_pkg::NUM_SRC];
	logic [17:0]           bidding;
	logic [7:0]            best;
	logic                  above;
	logic                  ack_level;
	logic                  ack_prev_reg;
	logic                  ack_fall;
	logic                  refresh_cmd;
	logic                  capture_now;
	logic [7:0]            vector_next;
	logic [1:0]            glb_chan;

	// Counts run 0..8; the bid field holds three bits, so eight reads as seven
	function automatic logic [2:0] sat3(input logic [3:0] count);
		return (count > 4'h7) ? 3'h7 : count[2:0];
	endfunction

	function automatic logic [3:0] chan_count(input logic [15:0] bus, input logic [1:0] ch);
		return bus[{ch, 2'b00} +: 4];
	endfunction

	// Receiver fill level reached for its select
	function automatic logic rx_level_ok(input logic [3:0] cnt, input logic [1:0] sel);
		unique case (sel)
			2'b00: return cnt >= 4'h1;
			2'b01: return cnt >= 4'h3;
			2'b10: return cnt >= 4'h6;
			2'b11: return cnt == qia_pkg::FIFO_DEPTH;
		endcase
	endfunction

	// Transmitter free-slot level reached for its select
	function automatic logic tx_level_ok(input logic [3:0] cnt, input logic [1:0] sel);
		unique case (sel)
			2'b00: return cnt == qia_pkg::FIFO_DEPTH;
			2'b01: return cnt >= 4'h4;
			2'b10: return cnt >= 4'h6;
			2'b11: return cnt >= 4'h1;
		endcase
	endfunction

	// Acknowledge pin arrives asynchronously
	qia_pin_sync #(.WIDTH(1), .INIT(1'b1)) u_ack_sync (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.pin    (interrupt_ack_n),
		.level  (ack_level)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_prev_reg <= 1'b1;
		end else if (ce) begin
			ack_prev_reg <= ack_level;
		end
	end

	assign ack_fall    = ack_prev_reg && !ack_level && (ack_state_reg == qia_pkg::QIA_ACK_IDLE);
	assign refresh_cmd = wr && (addr == qia_pkg::ADDR_COMMAND) && wdata[qia_pkg::CMD_REFRESH];
	assign capture_now = ack_fall || refresh_cmd;

	// Bid assembly; each source sets channel and type bits by wiring
	always_comb begin
		for (int c = 0; c < qia_pkg::NUM_CHAN; c++) begin
			logic [3:0] rc;
			logic [3:0] tf;
			logic [2:0] ta;
			rc = chan_count(rx_count, 2'(c));
			tf = chan_count(tx_free, 2'(c));
			// Saturated slot count; only its low two bits fit under the zero msb
			ta = sat3(tf);
			bid[c] = {sat3(rc), rx_error[c] ? qia_pkg::TYPE_RX_ERR : qia_pkg::TYPE_RX_OK,
				2'(c)};
			bidding[c] = interrupt_mask_reg[c] && (rc != 4'h0)
				&& rx_level_ok(rc, {mode_reg_zero[c][qia_pkg::RX_SEL0_BIT],
				mode_reg_one[c][qia_pkg::RX_SEL1_BIT]});
			bid[4 + c] = {1'b0, ta[1:0], qia_pkg::TYPE_TX, 2'(c)};
			bidding[4 + c] = interrupt_mask_reg[4 + c] && tx_enabled[c]
				&& (tf != 4'h0)
				&& tx_level_ok(tf, {mode_reg_zero[c][qia_pkg::TX_SEL_HI],
				mode_reg_zero[c][qia_pkg::TX_SEL_LO]});
			bid[8 + c] = {src_prog_reg[c][2:0], qia_pkg::TYPE_BREAK, 2'(c)};
			bidding[8 + c] = interrupt_mask_reg[8 + c] && break_det[c];
			bid[12 + c] = {src_prog_reg[c][5:3], qia_pkg::TYPE_CHANGE, 2'(c)};
			bidding[12 + c] = interrupt_mask_reg[12 + c] && change_det[c];
		end
		bid[16] = {timer_prog_reg[1:0], 1'b1, qia_pkg::TYPE_TIMER, qia_pkg::CHAN_CT_AB};
		bid[17] = {timer_prog_reg[3:2], 1'b1, qia_pkg::TYPE_TIMER, qia_pkg::CHAN_CT_CD};
		bidding[16] = interrupt_mask_reg[16] && timer_ready[0];
		bidding[17] = interrupt_mask_reg[17] && timer_ready[1];
	end

	// Highest enabled bid wins; type and channel bits make every bid unique
	always_comb begin
		best = 8'h00;
		for (int i = 0; i < qia_pkg::NUM_SRC; i++) begin
			if (bidding[i] && (bid[i] > best)) begin
				best = bid[i];
			end
		end
		above = best[7:qia_pkg::THRESH_LSB] > interrupt_control_reg[7:qia_pkg::THRESH_LSB];
	end

	// Evaluate alternates with hold; an acknowledge outside evaluate skips one pulse
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			arbitration_evaluate_reg         <= 1'b0;
			arbitration_evaluate_inhibit_reg <= 1'b0;
		end else if (ce) begin
			arbitration_evaluate_inhibit_reg <= ack_fall && !arbitration_evaluate_reg;
			arbitration_evaluate_reg         <= !arbitration_evaluate_reg && !arbitration_evaluate_inhibit_reg && !(ack_fall && !arbitration_evaluate_reg);
		end
	end

	// Trailing edge of evaluate latches the bus and the comparator result
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_latch_reg <= qia_pkg::NO_WINNER;
			win_valid_reg <= 1'b0;
		end else if (ce && arbitration_evaluate_reg) begin
			bus_latch_reg <= above ? best : qia_pkg::NO_WINNER;
			win_valid_reg <= above;
		end
	end

	// Open drain request: pulled low only while a winner clears the threshold
	assign interrupt_request_n_out  = 1'b0;
	assign interrupt_request_n_oe_n = !win_valid_reg;

	// Capture: data types take the live count, others keep their programmable field
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			current_interrupt_capture <= qia_pkg::NO_WINNER;
		end else if (ce && capture_now) begin
			if (!win_valid_reg) begin
				current_interrupt_capture <= qia_pkg::NO_WINNER;
			end else if (bus_latch_reg[3:2] == 2'b11) begin
				current_interrupt_capture <= {sat3(chan_count(rx_count, bus_latch_reg[1:0])),
					bus_latch_reg[4:0]};
			end else if (bus_latch_reg[4:2] == qia_pkg::TYPE_TX) begin
				current_interrupt_capture <= {sat3(chan_count(tx_free, bus_latch_reg[1:0])),
					bus_latch_reg[4:0]};
			end else begin
				current_interrupt_capture <= bus_latch_reg;
			end
		end
	end

	// Vector formats by control field
	always_comb begin
		unique case (interrupt_control_reg[1:0])
			qia_pkg::IVC_BASE: vector_next = vector_base_value;
			qia_pkg::IVC_CHAN: vector_next = {vector_base_value[7:2],
				current_interrupt_capture[1:0]};
			qia_pkg::IVC_TYPE: vector_next = {vector_base_value[7:5],
				current_interrupt_capture[4:0]};
			qia_pkg::IVC_NONE: vector_next = vector_base_value;
		endcase
	end

	// Acknowledge cycle: capture, drive vector with acknowledge pulse, hold till release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_state_reg  <= qia_pkg::QIA_ACK_IDLE;
			data_out       <= qia_pkg::RST_ZERO;
			data_oe_n      <= 1'b1;
			transfer_ack_n <= 1'b1;
		end else if (ce) begin
			transfer_ack_n <= 1'b1;
			unique case (ack_state_reg)
				qia_pkg::QIA_ACK_IDLE: begin
					if (ack_fall) begin
						ack_state_reg <= qia_pkg::QIA_ACK_CAPTURE;
					end
				end
				qia_pkg::QIA_ACK_CAPTURE: begin
					data_out       <= vector_next;
					data_oe_n      <= (interrupt_control_reg[1:0] == qia_pkg::IVC_NONE);
					transfer_ack_n <= 1'b0;
					ack_state_reg  <= qia_pkg::QIA_ACK_DRIVE;
				end
				qia_pkg::QIA_ACK_DRIVE: begin
					ack_state_reg <= qia_pkg::QIA_ACK_WAIT;
				end
				qia_pkg::QIA_ACK_WAIT: begin
					if (ack_level) begin
						data_oe_n     <= 1'b1;
						ack_state_reg <= qia_pkg::QIA_ACK_IDLE;
					end
				end
			endcase
		end
	end

	assign glb_chan = current_interrupt_capture[1:0];

	// Software-written configuration
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			interrupt_control_reg <= qia_pkg::RST_ZERO;
			vector_base_value     <= qia_pkg::RST_ZERO;
			interrupt_mask_reg    <= 18'h00000;
			timer_prog_reg        <= 4'h0;
			for (int c = 0; c < qia_pkg::NUM_CHAN; c++) begin
				mode_reg_zero[c] <= qia_pkg::RST_ZERO;
				mode_reg_one[c]  <= qia_pkg::RST_ZERO;
				src_prog_reg[c]  <= 6'h00;
			end
		end else if (ce && wr) begin
			if (addr == qia_pkg::ADDR_CTRL) interrupt_control_reg <= wdata;
			if (addr == qia_pkg::ADDR_VEC_BASE) vector_base_value <= wdata;
			if (addr == qia_pkg::ADDR_MASK_LO) interrupt_mask_reg[7:0] <= wdata;
			if (addr == qia_pkg::ADDR_MASK_MID) interrupt_mask_reg[15:8] <= wdata;
			if (addr == qia_pkg::ADDR_MASK_HI) interrupt_mask_reg[17:16] <= wdata[1:0];
			if (addr == qia_pkg::ADDR_CT_PROG) timer_prog_reg <= wdata[3:0];
			if (addr[4:2] == qia_pkg::ADDR_MODE0[4:2]) mode_reg_zero[addr[1:0]] <= wdata;
			if (addr[4:2] == qia_pkg::ADDR_MODE1[4:2]) mode_reg_one[addr[1:0]] <= wdata;
			if (addr[4:2] == qia_pkg::ADDR_SRC_PROG[4:2]) src_prog_reg[addr[1:0]] <= wdata[5:0];
		end
	end

	// FIFO strobes: global accesses steer to the captured channel
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_pop  <= 4'h0;
			tx_push <= 4'h0;
			tx_data <= qia_pkg::RST_ZERO;
		end else if (ce) begin
			rx_pop  <= 4'h0;
			tx_push <= 4'h0;
			if (rd && addr == qia_pkg::ADDR_GLB_DATA) rx_pop[glb_chan] <= 1'b1;
			if (rd && addr[4:2] == qia_pkg::ADDR_LOC_DATA[4:2]) rx_pop[addr[1:0]] <= 1'b1;
			if (wr && addr == qia_pkg::ADDR_GLB_DATA) begin
				tx_push[glb_chan] <= 1'b1;
				tx_data           <= wdata;
			end
			if (wr && addr[4:2] == qia_pkg::ADDR_LOC_DATA[4:2]) begin
				tx_push[addr[1:0]] <= 1'b1;
				tx_data            <= wdata;
			end
		end
	end

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= qia_pkg::RST_ZERO;
		end else if (ce) begin
			rdata <= qia_pkg::RST_ZERO;
			if (rd) begin
				if (addr == qia_pkg::ADDR_CTRL) rdata <= interrupt_control_reg;
				if (addr == qia_pkg::ADDR_VEC_BASE) rdata <= vector_base_value;
				if (addr == qia_pkg::ADDR_MASK_LO) rdata <= interrupt_mask_reg[7:0];
				if (addr == qia_pkg::ADDR_MASK_MID) rdata <= interrupt_mask_reg[15:8];
				if (addr == qia_pkg::ADDR_MASK_HI) rdata <= {6'h00, interrupt_mask_reg[17:16]};
				if (addr == qia_pkg::ADDR_CT_PROG) rdata <= {4'h0, timer_prog_reg};
				if (addr == qia_pkg::ADDR_CAPTURE) rdata <= current_interrupt_capture;
				if (addr == qia_pkg::ADDR_GLB_COUNT) begin
					rdata <= {5'h00, current_interrupt_capture[7:5]};
				end
				if (addr == qia_pkg::ADDR_GLB_CHAN) rdata <= {6'h00, glb_chan};
				if (addr == qia_pkg::ADDR_GLB_DATA) rdata <= rx_data[{glb_chan, 3'b000} +: 8];
				if (addr[4:2] == qia_pkg::ADDR_MODE0[4:2]) rdata <= mode_reg_zero[addr[1:0]];
				if (addr[4:2] == qia_pkg::ADDR_MODE1[4:2]) rdata <= mode_reg_one[addr[1:0]];
				if (addr[4:2] == qia_pkg::ADDR_LOC_DATA[4:2]) rdata <= rx_data[{addr[1:0], 3'b000} +: 8];
				if (addr[4:2] == qia_pkg::ADDR_SRC_PROG[4:2]) rdata <= {2'h0, src_prog_reg[addr[1:0]]};
			end
		end
	end

	// Checks next to the logic
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	req_follows_win_a: assert property (interrupt_request_n_oe_n == !win_valid_reg)
		else $error("request output differs from latched winner");
	no_win_ones_a: assert property (!win_valid_reg |-> bus_latch_reg == 8'hFF)
		else $error("idle interrupt bus not all ones");
	arbitration_evaluate_latch_a: assert property (ce && arbitration_evaluate_reg |=>
		bus_latch_reg == ($past(above) ? $past(best) : 8'hFF))
		else $error("evaluate did not latch winner");
	capture_hold_a: assert property (!capture_now |=> $stable(current_interrupt_capture))
		else $error("capture changed without acknowledge or refresh");
	tx_msb_zero_a: assert property (bid[4][7] == 1'b0 && bid[7][7] == 1'b0)
		else $error("transmitter bid msb set");
	rx_empty_quiet_a: assert property (rx_count[3:0] == 4'h0 |-> !bidding[0])
		else $error("empty receiver bids");
	timer_chan_a: assert property (bid[16][1:0] == 2'h1 && bid[17][1:0] == 2'h3)
		else $error("timer channel wrong");
	glb_count_a: assert property (rd && ce && addr == qia_pkg::ADDR_GLB_COUNT |=>
		rdata == {5'h00, $past(current_interrupt_capture[7:5])})
		else $error("global count read wrong");
	ack_pulse_a: assert property (ce && ack_state_reg == qia_pkg::QIA_ACK_CAPTURE |=>
		!transfer_ack_n ##1 (transfer_ack_n || !ce))
		else $error("acknowledge pulse malformed");
	no_vec_a: assert property (ce && ack_state_reg == qia_pkg::QIA_ACK_CAPTURE &&
		interrupt_control_reg[1:0] == 2'h3 |=> data_oe_n)
		else $error("vector driven with control 11");
	glb_pop_a: assert property (ce && rd && addr == qia_pkg::ADDR_GLB_DATA |=> rx_pop[$past(glb_chan)])
		else $error("global read not steered");

	ack_seen_c: cover property (ack_fall ##[1:8] !transfer_ack_n);
	refresh_c: cover property (refresh_cmd && win_valid_reg);
	req_drop_c: cover property (win_valid_reg ##1 !win_valid_reg);
endmodule

// File: verification/qia_host_model.sv
// Host model that runs interrupt acknowledge cycles against the arbiter
`timescale 1ns/1ps
module qia_host_model (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic       transfer_ack_n,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe_n,
	output logic            interrupt_ack_n,
	output logic      [7:0] bus,
	output logic      [7:0] vec_seen,
	output logic            driven,
	output logic            done
);
	logic [7:0] last_bus = 8'h00;
	int         n;
	// A released bus shows the inverse of its last level, so stale data never passes
	assign bus = data_oe_n ? ~last_bus : data_out;
	always @(posedge clk) last_bus <= bus;
	// One acknowledge per start; hold it low until the strobe is sampled low
	initial begin
		interrupt_ack_n = 1'b1;
		done = 1'b0;
		driven = 1'b0;
		vec_seen = 8'h00;
		forever begin
			@(posedge clk);
			if (start) begin
				done <= 1'b0;
				interrupt_ack_n <= 1'b0;
				n = 0;
				@(posedge clk);
				while (transfer_ack_n !== 1'b0 && n < 40) begin
					@(posedge clk);
					n++;
				end
				vec_seen <= bus;
				driven <= (data_oe_n === 1'b0) && (n < 40);
				interrupt_ack_n <= 1'b1;
				done <= (n < 40);
			end
		end
	end
endmodule

// File: verification/quad_uart_interrupt_arbiter_tb.sv
// Self-checking bench for the quad UART interrupt arbiter
`timescale 1ns/1ps
module quad_uart_interrupt_arbiter_tb;
	typedef struct packed {
		logic [15:0] cnt;
		logic [3:0]  err;
		logic [7:0]  exp;
	} qia_row_t;
	logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, start = 1'b0;
	logic        ack_n, req_oe_n, doe_n, tack_n, done, driven;
	logic [4:0]  addr = 5'h00;
	logic [7:0]  wdata = 8'h00, tx_data, dout, bus, vec, v, rdata;
	logic [15:0] rx_count = 16'h0000, tx_free = 16'h0000;
	logic [3:0]  rx_error = 4'h0, tx_en = 4'h0, brk = 4'h0, rx_pop, tx_push, p;
	logic [31:0] rx_data = 32'hD3C2B1A0;
	logic [7:0]  ev [3] = '{8'hA5, 8'hA4, 8'hAC};
	int          err_total = 0, n_compared = 0, cyc = 0;
	qia_row_t    rows [5] = '{'{16'h0000, 4'h0, 8'hFF}, '{16'h0100, 4'h0, 8'h2E},
		'{16'h2003, 4'h0, 8'h6C}, '{16'h0080, 4'h0, 8'hED}, '{16'h0220, 4'h2, 8'h5D}};

	qia_arbiter qia_arbiter_inst (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_count(rx_count),
		.tx_free(tx_free), .rx_error(rx_error), .tx_enabled(tx_en), .break_det(brk),
		.change_det(4'h0), .timer_ready(2'h0), .rx_data(rx_data), .rx_pop(rx_pop),
		.tx_push(tx_push), .tx_data(tx_data), .interrupt_ack_n(ack_n),
		.interrupt_request_n_out(), .interrupt_request_n_oe_n(req_oe_n), .data_in(bus),
		.data_out(dout), .data_oe_n(doe_n), .transfer_ack_n(tack_n));
	qia_host_model qia_host_model_inst (.clk(clk), .start(start), .transfer_ack_n(tack_n),
		.data_out(dout), .data_oe_n(doe_n), .interrupt_ack_n(ack_n), .bus(bus),
		.vec_seen(vec), .driven(driven), .done(done));

	// Free-running clock, 50 ns period
	initial forever #25 clk = ~clk;

	// Compare one value and report a mismatch at once
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d, output logic [3:0] q);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		q = rx_pop;
	endtask
	// Let arbitration settle, refresh the capture, then check capture and request
	task automatic run(input logic [15:0] c, input logic [7:0] x, input logic [7:0] m);
		rx_count <= c;
		repeat (6) @(posedge clk);
		wr_reg(qia_pkg::ADDR_COMMAND, 8'h01);
		rd_reg(qia_pkg::ADDR_CAPTURE, v, p);
		chk(v & m, x, "capture");
		chk({7'h00, req_oe_n}, {7'h00, x === 8'hFF}, "request");
	endtask

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rd_reg(qia_pkg::ADDR_CAPTURE, v, p);
		chk(v, qia_pkg::NO_WINNER, "capture reset");
		chk({6'h00, req_oe_n, doe_n}, 8'h03, "idle pins");
		rd_reg(5'h0B, v, p);
		chk(v, 8'h00, "unmapped read");
		wr_reg(qia_pkg::ADDR_MASK_LO, 8'h0F);
		// Receiver bids: empty, single, competing, full, error type
		foreach (rows[i]) begin
			rx_error <= rows[i].err;
			run(rows[i].cnt, rows[i].exp, 8'hFF);
			if (rows[i].exp !== 8'hFF) begin
				rd_reg(qia_pkg::ADDR_GLB_DATA, v, p);
				chk({4'h0, p}, 8'h01 << rows[i].exp[1:0], "global pop");
				chk(v, rx_data[rows[i].exp[1:0]*8 +: 8], "global data");
			end
		end
		wr_reg(qia_pkg::ADDR_GLB_DATA, 8'h3C);
		@(negedge clk);
		chk({tx_push, tx_data[7:4]}, 8'h23, "global push");
		rx_error <= 4'h0;
		// Capture holds until acknowledge or refresh
		rx_count <= 16'h0003;
		repeat (6) @(posedge clk);
		rd_reg(qia_pkg::ADDR_CAPTURE, v, p);
		chk(v, 8'h5D, "capture hold");
		wr_reg(qia_pkg::ADDR_VEC_BASE, 8'hA5);
		for (int k = 0; k < 4; k++) begin
			wr_reg(qia_pkg::ADDR_CTRL, 8'(k));
			@(posedge clk);
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			@(posedge clk);
			for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk);
			chk({7'h00, done}, 8'h01, "ack strobe");
			chk({7'h00, driven}, {7'h00, k != 3}, "vector driven");
			if (k != 3) chk(vec, ev[k], "vector");
			repeat (8) @(posedge clk);
			chk({7'h00, doe_n}, 8'h01, "bus release");
		end
		rd_reg(qia_pkg::ADDR_CAPTURE, v, p);
		chk(v, 8'h6C, "ack capture");
		wr_reg(qia_pkg::ADDR_CTRL, 8'h00);
		// Fill-level select 01 needs three bytes, 11 needs all eight
		wr_reg(5'h10, 8'h40);
		run(16'h0002, 8'hFF, 8'hFF);
		run(16'h0003, 8'h6C, 8'hFF);
		wr_reg(5'h0C, 8'h40);
		run(16'h0007, 8'hFF, 8'hFF);
		run(16'h0008, 8'hEC, 8'hFF);
		wr_reg(5'h0C, 8'h00);
		wr_reg(5'h10, 8'h00);
		// Transmitter: empty bids, one byte loaded withdraws, high threshold blocks
		wr_reg(qia_pkg::ADDR_MASK_LO, 8'hF0);
		tx_en <= 4'h1;
		tx_free <= 16'h0008;
		run(16'h0000, 8'h08, 8'h1F);
		tx_free <= 16'h0007;
		run(16'h0000, 8'hFF, 8'hFF);
		tx_free <= 16'h0008;
		wr_reg(qia_pkg::ADDR_CTRL, 8'h80);
		run(16'h0000, 8'hFF, 8'hFF);
		// Break bid follows its source level and clears with it
		wr_reg(qia_pkg::ADDR_CTRL, 8'h00);
		wr_reg(qia_pkg::ADDR_MASK_LO, 8'h00);
		wr_reg(qia_pkg::ADDR_MASK_MID, 8'h08);
		wr_reg(5'h1B, 8'h07);
		brk <= 4'h8;
		run(16'h0000, 8'hF3, 8'hFF);
		brk <= 4'h0;
		run(16'h0000, 8'hFF, 8'hFF);
		conclude();
	end
endmodule
